/* hw/lsd_core.sv */
/*
  lsd_core: eight-string pulse-width dimming engine with apb registers.
  assumes pins arrive asynchronous to mclk_i; pready is always high.
*/
// Our own choices: the APB slave port and the register offsets.
// Operation
// - sync dimming to frame phase and shift clock
// - programmable phase per string
// - all eight widths accepted in one burst
// - six-bit current trim per string
// - global width from intensity or dim input
// - eight-bit pulse width per string
// - six-bit derating shared by all strings
// - ten-bit final on time per string
// - fault output pulled low on fault
// - fault held until read or disable
// - bus address from two select pins
// - run when enabled, shut down otherwise
// - shift clock steps the dimming counter
// - direct drive when both bits set
`timescale 1ns/10ps
module lsd_core #(
  parameter logic [4:0] ADDR_BASE = 5'h0a   // arbitrary upper address bits
) (
  // clock and reset
  input  wire logic                mclk_i,
  input  wire logic                rst_i,
  // apb slave
  input  wire logic                psel_i,
  input  wire logic                penable_i,
  input  wire logic                pwrite_i,
  input  wire logic [7:0]          paddr_i,
  input  wire logic [31:0]         pwdata_i,
  output logic      [31:0]         prdata_o,
  output logic                     pready_o,
  output logic                     pslverr_o,
  // pins from outside
  input  wire logic                enable_i,
  input  wire logic                frame_phase_input_i,
  input  wire logic                shift_clk_i,
  input  wire logic                dim_input_i,
  input  wire logic                addr_select_lo_i,
  input  wire logic                addr_select_hi_i,
  input  wire logic [7:0]          string_fault_i,
  // outputs
  output logic      [7:0]          gate_o,
  output logic      [47:0]         string_current_trim_o,
  output logic      [6:0]          bus_addr_o,
  output logic                     fault_flag_n_o,
  output logic                     fault_flag_n_oe_o,
  output logic                     irq_o
);
  localparam int N = lsd_pkg::NSTR;

  // two-flop synchronisers for all pins
  logic [13:0] s1_q, s2_q;
  logic [13:0] pin_w;
  assign pin_w = {string_fault_i, addr_select_hi_i, addr_select_lo_i,
                  dim_input_i, shift_clk_i, frame_phase_input_i, enable_i};
  always_ff @(posedge mclk_i or posedge rst_i)
    if (rst_i)
    begin
      s1_q <= 14'h0000;
      s2_q <= 14'h0000;
    end
    else
    begin
      s1_q <= pin_w;
      s2_q <= s1_q;
    end

  logic       en_s, fph_s, gsc_s, dim_s;
  logic [7:0] flt_s;
  assign en_s  = s2_q[0];
  assign fph_s = s2_q[1];
  assign gsc_s = s2_q[2];
  assign dim_s = s2_q[3];
  assign flt_s = s2_q[13:6];

  // delayed copies for edge finding
  logic fph_d_q, gsc_d_q;
  always_ff @(posedge mclk_i or posedge rst_i)
    if (rst_i)
    begin
      fph_d_q <= 1'b0;
      gsc_d_q <= 1'b0;
    end
    else
    begin
      fph_d_q <= fph_s;
      gsc_d_q <= gsc_s;
    end

  // address from select pins, refreshed every cycle
  always_ff @(posedge mclk_i or posedge rst_i)
    if (rst_i)
      bus_addr_o <= 7'h00;
    else
      bus_addr_o <= {ADDR_BASE, s2_q[5], s2_q[4]};

  // apb decode; no wait states
  logic wr, rd;
  logic [2:0] idx;
  assign wr = psel_i & penable_i & pwrite_i;
  assign rd = psel_i & penable_i & ~pwrite_i;
  assign idx = paddr_i[4:2];
  assign pready_o = 1'b1;

  // software registers; width, phase, intensity and derating are shadow copies until frame start
  lsd_pkg::lsd_ctrl_t ctrl_q;
  logic [5:0] intens_q, drt_q;
  logic [7:0] pwm_q [N];
  logic [5:0] trim_q [N];
  logic [9:0] phs_q [N];
  logic [1:0] imsk_q;
  always_ff @(posedge mclk_i or posedge rst_i)
    if (rst_i)
    begin
      ctrl_q <= lsd_pkg::CTRL_RST;
      intens_q <= lsd_pkg::INTENS_RST;
      drt_q  <= lsd_pkg::DRT_RST;
      imsk_q <= 2'h0;
      for (int i = 0; i < N; i++)
      begin
        pwm_q[i]  <= lsd_pkg::PWM_RST;
        trim_q[i] <= lsd_pkg::TRIM_RST;
        phs_q[i]  <= lsd_pkg::PHS_RST;
      end
    end
    else if (wr)
    begin
      // widths land in shadows, so a burst of eight is one update
      unique case (paddr_i[7:5])
        3'h0:
          unique case (paddr_i[4:0])
            lsd_pkg::CTRL_OFF[4:0]: ctrl_q <= pwdata_i[2:0];
            lsd_pkg::INTENS_OFF[4:0]: intens_q <= pwdata_i[5:0];
            lsd_pkg::DRT_OFF[4:0]:  drt_q  <= pwdata_i[5:0];
            lsd_pkg::IMSK_OFF[4:0]: imsk_q <= pwdata_i[1:0];
            default: ;
          endcase
        3'h1: pwm_q[idx]  <= pwdata_i[7:0];
        3'h2: trim_q[idx] <= pwdata_i[5:0];
        3'h3: phs_q[idx]  <= pwdata_i[9:0];
        default: ;
      endcase
    end

  // trim drives the current regulator directly
  always_ff @(posedge mclk_i or posedge rst_i)
    if (rst_i)
      string_current_trim_o <= {N{lsd_pkg::TRIM_RST}};
    else
      for (int i = 0; i < N; i++)
        string_current_trim_o[i*6 +: 6] <= trim_q[i];

  // dimming counter steps on rising shift clock edges
  logic [9:0] cnt_q;
  logic step, frame;
  assign step  = gsc_s & ~gsc_d_q;
  // frame start from phase input, or counter wrap when free running
  assign frame = ctrl_q.sync_en ? (fph_s & ~fph_d_q)
                                : (step & (cnt_q == lsd_pkg::ON_FULL));
  always_ff @(posedge mclk_i or posedge rst_i)
    if (rst_i)
      cnt_q <= 10'h000;
    else if (!en_s || frame)
      cnt_q <= 10'h000;
    else if (step)
      cnt_q <= cnt_q + 10'h001;

  // live copies, loaded only at frame start
  logic [7:0] pwm_l_q [N];
  logic [9:0] phs_l_q [N];
  logic [5:0] intens_l_q, drt_l_q;
  always_ff @(posedge mclk_i or posedge rst_i)
    if (rst_i)
    begin
      intens_l_q <= lsd_pkg::INTENS_RST;
      drt_l_q  <= lsd_pkg::DRT_RST;
      for (int i = 0; i < N; i++)
      begin
        pwm_l_q[i] <= lsd_pkg::PWM_RST;
        phs_l_q[i] <= lsd_pkg::PHS_RST;
      end
    end
    else if (frame)
    begin
      intens_l_q <= intens_q;
      drt_l_q  <= drt_q;
      for (int i = 0; i < N; i++)
      begin
        pwm_l_q[i] <= pwm_q[i];
        phs_l_q[i] <= phs_q[i];
      end
    end

  // on time and gate per string
  logic [9:0] on_w [N];
  logic [7:0] gate_d;
  logic ext_g, direct;
  // external input replaces intensity as global width source
  assign ext_g  = ctrl_q.dim_en & ~ctrl_q.direct;
  assign direct = ctrl_q.dim_en & ctrl_q.direct;
  for (genvar g = 0; g < N; g++)
  begin : g_str
    logic [19:0] prod;
    logic [5:0]  gl;
    logic [9:0]  rel;
    // in external mode global factor is full, input gates instead
    assign gl   = ext_g ? 6'h3f : intens_l_q;
    assign prod = 20'(pwm_l_q[g]) * 20'(gl + 7'h01) * 20'(drt_l_q + 7'h01);
    // all-max factors mean continuous on
    assign on_w[g] = (pwm_l_q[g] == 8'hff && gl == 6'h3f && drt_l_q == 6'h3f)
                     ? lsd_pkg::ON_FULL : prod[19:10];
    assign rel = cnt_q - phs_l_q[g];
    always_comb
    begin
      if (!en_s)
        gate_d[g] = 1'b0;
      else if (direct)
        gate_d[g] = dim_s;
      else
        gate_d[g] = ((on_w[g] == lsd_pkg::ON_FULL) || (rel < on_w[g]))
                    && (!ext_g || dim_s);
    end
  end

  always_ff @(posedge mclk_i or posedge rst_i)
    if (rst_i)
      gate_o <= 8'h00;
    else
      gate_o <= gate_d;

  // sticky fault status; event wins over read clear, disable clears all
  logic [7:0] flt_q;
  logic rd_flt;
  assign rd_flt = rd && paddr_i == lsd_pkg::FLT_OFF;
  always_ff @(posedge mclk_i or posedge rst_i)
    if (rst_i)
      flt_q <= 8'h00;
    else if (!en_s)
      flt_q <= 8'h00;
    else
      flt_q <= (rd_flt ? 8'h00 : flt_q) | flt_s;

  // open-drain fault pin: drive low while any fault held
  assign fault_flag_n_o    = 1'b0;
  assign fault_flag_n_oe_o = |flt_q;

  // irq status, write one to clear, set wins
  logic [1:0] ist_q, ev;
  assign ev = {|(flt_s & ~flt_q), frame};
  always_ff @(posedge mclk_i or posedge rst_i)
    if (rst_i)
      ist_q <= 2'h0;
    else if (wr && paddr_i == lsd_pkg::IST_OFF)
      ist_q <= (ist_q & ~pwdata_i[1:0]) | ev;
    else
      ist_q <= ist_q | ev;
  assign irq_o = |(ist_q & imsk_q);

  // read mux and unmapped detection
  always_comb
  begin
    prdata_o  = 32'h0000_0000;
    pslverr_o = 1'b0;
    unique case (paddr_i[7:5])
      3'h0:
        unique case (paddr_i[4:0])
          lsd_pkg::CTRL_OFF[4:0]: prdata_o[2:0] = ctrl_q;
          lsd_pkg::INTENS_OFF[4:0]: prdata_o[5:0] = intens_q;
          lsd_pkg::DRT_OFF[4:0]:  prdata_o[5:0] = drt_q;
          lsd_pkg::FLT_OFF[4:0]:  prdata_o[7:0] = flt_q;
          lsd_pkg::IST_OFF[4:0]:  prdata_o[1:0] = ist_q;
          lsd_pkg::IMSK_OFF[4:0]: prdata_o[1:0] = imsk_q;
          lsd_pkg::ADDR_OFF[4:0]: prdata_o[6:0] = bus_addr_o;
          default: pslverr_o = psel_i & penable_i;
        endcase
      3'h1: prdata_o[7:0] = pwm_q[idx];
      3'h2: prdata_o[5:0] = trim_q[idx];
      3'h3: prdata_o[9:0] = phs_q[idx];
      default: pslverr_o = psel_i & penable_i;
    endcase
  end

  // checks
  fault_drive_a: assert property (@(posedge mclk_i) disable iff (rst_i)
    en_s && |flt_s |=> fault_flag_n_oe_o)
    else $error("fault pin not driven");
  fault_hold_a: assert property (@(posedge mclk_i) disable iff (rst_i)
    (|flt_q) && !rd_flt && en_s |=> fault_flag_n_oe_o)
    else $error("fault released early");
  en_off_a: assert property (@(posedge mclk_i) disable iff (rst_i)
    !en_s |=> gate_o == 8'h00)
    else $error("gates on while disabled");
  frame_cnt_a: assert property (@(posedge mclk_i) disable iff (rst_i)
    frame |=> cnt_q == 10'h000)
    else $error("counter not restarted at frame");
  direct_a: assert property (@(posedge mclk_i) disable iff (rst_i)
    en_s && direct |=> gate_o == {8{$past(dim_s)}})
    else $error("direct drive mismatch");
  live_hold_a: assert property (@(posedge mclk_i) disable iff (rst_i)
    !frame |=> pwm_l_q[0] == $past(pwm_l_q[0]))
    else $error("width changed mid frame");
  addr_pins_a: assert property (@(posedge mclk_i) disable iff (rst_i)
    ##1 bus_addr_o[1:0] == $past(s2_q[5:4]))
    else $error("bus address not from pins");
  trim_out_a: assert property (@(posedge mclk_i) disable iff (rst_i)
    wr && paddr_i == lsd_pkg::TRIM_OFF |=> ##1 string_current_trim_o[5:0] == $past(pwdata_i[5:0], 2))
    else $error("trim not applied");
  step_cnt_a: assert property (@(posedge mclk_i) disable iff (rst_i)
    en_s && step && !frame |=> cnt_q == $past(cnt_q) + 10'h001)
    else $error("counter missed a step");
  full_on_a: assert property (@(posedge mclk_i) disable iff (rst_i)
    en_s && !ctrl_q.dim_en && on_w[2] == lsd_pkg::ON_FULL |=> gate_o[2])
    else $error("full scale not continuous");

endmodule // lsd_core

/* hw/lsd_pkg.sv */
/*
  lsd_pkg: shared constants and types of the eight-string dimming engine.
  assumes a 32-bit apb slave, word-aligned registers, 200 MHz mclk.
*/
package lsd_pkg;
  localparam int NSTR = 8;                 // number of strings
  // register byte offsets
  localparam logic [7:0] CTRL_OFF  = 8'h00;
  localparam logic [7:0] INTENS_OFF = 8'h04; // global intensity
  localparam logic [7:0] DRT_OFF   = 8'h08;
  localparam logic [7:0] FLT_OFF   = 8'h0c;
  localparam logic [7:0] IST_OFF   = 8'h10;
  localparam logic [7:0] IMSK_OFF  = 8'h14;
  localparam logic [7:0] ADDR_OFF  = 8'h18;
  localparam logic [7:0] PWM_OFF   = 8'h20; // +4 per string
  localparam logic [7:0] TRIM_OFF  = 8'h40; // +4 per string
  localparam logic [7:0] PHS_OFF   = 8'h60; // +4 per string
  // reset values
  localparam logic [5:0] INTENS_RST = 6'h3f;
  localparam logic [5:0] DRT_RST   = 6'h3f;
  localparam logic [5:0] TRIM_RST  = 6'h3f;
  localparam logic [7:0] PWM_RST   = 8'h00;
  localparam logic [9:0] PHS_RST   = 10'h000;
  localparam logic [9:0] ON_FULL   = 10'h3ff;
  // irq bit positions
  localparam int IRQ_FRAME = 0;
  localparam int IRQ_FAULT = 1;
  // control fields
  typedef struct packed {
    logic sync_en;    // frame from phase input, else counter wrap
    logic direct;     // direct_dim_select
    logic dim_en;     // dim_input_enable
  } lsd_ctrl_t;
  localparam lsd_ctrl_t CTRL_RST = '{sync_en: 1'b0, direct: 1'b0, dim_en: 1'b0};
endpackage

/* sim/lsd_video_src.sv */
/*
  lsd_video_src: model of the video timing source on the link pins.
  assumes one bench process calls its tasks; the link clock is free of mclk.
*/
`timescale 1ns/10ps
module lsd_video_src (
  // link pins
  output logic frame_o,
  output logic shift_o,
  output logic dim_o
);
  // unused pins are held low
  initial
  begin
    frame_o = 1'b0;
    shift_o = 1'b0;
    dim_o   = 1'b0;
  end
  // one frame mark, long enough for the 2-flop sync
  task automatic frame();
    #42 frame_o = 1'b1;
    #40 frame_o = 1'b0;
  endtask
  // n link clock periods of 160 ns, then stand still low
  task automatic steps(input int n);
    #2;
    repeat (n)
    begin
      #80 shift_o = 1'b1;
      #80 shift_o = 1'b0;
    end
  endtask
  // external dim level, any duty
  task automatic dim(input logic v);
    dim_o <= v;
  endtask
endmodule // lsd_video_src

/* sim/lsd_core_tb_top.sv */
/*
  lsd_core_tb_top: self-checking bench of the dimming engine.
  assumes pready answers in its own time; fault pin has a pull-up.
*/
`timescale 1ns/10ps
module lsd_core_tb_top;
  localparam logic [4:0] ABASE = 5'h0a; // arbitrary upper address bits
  logic        mclk = 1'b0, rst = 1'b1, psel = 1'b0, pen = 1'b0, pwr = 1'b0;
  logic [7:0]  paddr = 8'h00, sfault = 8'h00, gate;
  logic [31:0] pwd = 32'h0, prd, rd;
  logic        prdy, perr, err, en = 1'b1, fn, fn_oe, irq, frm, shc, dim;
  logic        asl = 1'b0, ash = 1'b1; // address select pins
  logic [47:0] trim;
  logic [6:0]  baddr;
  int          n_mismatch = 0, checks_done = 0, cyc = 0;
  int          pw[8], ph[8];
  wire         fline = fn_oe ? fn : 1'b1; // open drain with pull-up
  always #2.5 mclk = ~mclk;
  lsd_video_src vid (.frame_o(frm), .shift_o(shc), .dim_o(dim));
  lsd_core #(.ADDR_BASE(ABASE)) dut (.mclk_i(mclk), .rst_i(rst), .psel_i(psel),
    .penable_i(pen), .pwrite_i(pwr), .paddr_i(paddr), .pwdata_i(pwd), .prdata_o(prd),
    .pready_o(prdy), .pslverr_o(perr), .enable_i(en), .frame_phase_input_i(frm),
    .shift_clk_i(shc), .dim_input_i(dim), .addr_select_lo_i(asl),
    .addr_select_hi_i(ash), .string_fault_i(sfault), .gate_o(gate),
    .string_current_trim_o(trim), .bus_addr_o(baddr), .fault_flag_n_o(fn),
    .fault_flag_n_oe_o(fn_oe), .irq_o(irq));
  // hang guard
  always @(posedge mclk)
  begin
    cyc <= cyc + 1;
    if (cyc == 20000)
    begin
      n_mismatch++;
      stop_test();
    end
  end
  task automatic stop_test();
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task automatic chk(input logic [47:0] got, input logic [47:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic waitc(input int n);
    repeat (n) @(posedge mclk);
  endtask
  // apb transfer: setup, then access until pready
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    psel <= 1'b1;
    pwr <= w;
    paddr <= a;
    pwd <= d;
    @(posedge mclk);
    pen <= 1'b1;
    @(posedge mclk);
    while (prdy !== 1'b1) @(posedge mclk);
    rd = prd;
    err = perr;
    psel <= 1'b0;
    pen <= 1'b0;
  endtask
  // expected gates for a counter value
  function automatic logic [7:0] exp_gate(input int c, input int g, input int d);
    exp_gate = 8'h00;
    for (int i = 0; i < 8; i++)
      if ((((c - ph[i]) & 1023) < ((pw[i] * (g + 1) * (d + 1)) >> 10))
          || (pw[i] == 255 && g == 63 && d == 63))
        exp_gate[i] = 1'b1;
  endfunction
  task automatic t_regs();
    bus(1'b0, lsd_pkg::INTENS_OFF, 32'h0);
    chk(48'(rd), 48'(lsd_pkg::INTENS_RST));
    chk(trim, {8{lsd_pkg::TRIM_RST}});
    bus(1'b1, lsd_pkg::TRIM_OFF + 8'h0c, 32'h15);
    bus(1'b1, lsd_pkg::TRIM_OFF, 32'h2a);
    waitc(2);
    chk(48'(trim[23:18]), 48'h15);
    chk(48'(trim[5:0]), 48'h2a);
    bus(1'b0, 8'hfc, 32'h0);
    chk(48'(err), 48'h1);
    chk(48'(rd), 48'h0);
    chk(48'(baddr), 48'({ABASE, 2'b10}));
    // swap the select pins; three flops before the address moves
    asl <= 1'b1;
    ash <= 1'b0;
    waitc(6);
    chk(48'(baddr), 48'({ABASE, 2'b01}));
    $display("done regs");
  endtask
  task automatic t_pwm();
    pw = '{2, 128, 255, 0, 1, 1, 1, 1};
    ph = '{0, 0, 8, 0, 0, 0, 0, 0};
    bus(1'b1, lsd_pkg::CTRL_OFF, 32'h4);
    for (int i = 0; i < 8; i++) bus(1'b1, lsd_pkg::PWM_OFF + 8'(4 * i), 32'(pw[i]));
    bus(1'b1, lsd_pkg::PHS_OFF + 8'h08, 32'h8);
    bus(1'b1, lsd_pkg::DRT_OFF, 32'h1f);
    waitc(8);
    chk(48'(gate), 48'h0);
    vid.frame();
    waitc(8);
    chk(48'(gate), 48'(exp_gate(0, 63, 31)));
    bus(1'b0, lsd_pkg::IST_OFF, 32'h0);
    chk(48'(rd[0]), 48'h1);
    vid.steps(3);
    waitc(8);
    chk(48'(gate), 48'(exp_gate(3, 63, 31)));
    vid.steps(1);
    waitc(8);
    chk(48'(gate), 48'(exp_gate(4, 63, 31)));
    vid.steps(4);
    waitc(8);
    chk(48'(gate), 48'(exp_gate(8, 63, 31)));
    // all factors at full: string 2 stays on where its window ends
    bus(1'b1, lsd_pkg::DRT_OFF, 32'h3f);
    vid.frame();
    vid.steps(4);
    waitc(8);
    chk(48'(gate), 48'(exp_gate(4, 63, 63)));
    bus(1'b1, lsd_pkg::INTENS_OFF, 32'h1f);
    vid.frame();
    vid.steps(4);
    waitc(8);
    chk(48'(gate), 48'(exp_gate(4, 31, 63)));
    $display("done pwm");
  endtask
  task automatic t_dim();
    bus(1'b1, lsd_pkg::CTRL_OFF, 32'h3);
    vid.dim(1'b1);
    waitc(8);
    chk(48'(gate), 48'hff);
    vid.dim(1'b0);
    waitc(8);
    chk(48'(gate), 48'h0);
    bus(1'b1, lsd_pkg::CTRL_OFF, 32'h1);
    waitc(8);
    chk(48'(gate), 48'h0);
    // input high: global factor counts as full, not the intensity
    vid.dim(1'b1);
    waitc(8);
    chk(48'(gate), 48'(exp_gate(4, 63, 63)));
    vid.dim(1'b0);
    bus(1'b1, lsd_pkg::CTRL_OFF, 32'h4);
    $display("done dim");
  endtask
  task automatic t_fault();
    bus(1'b1, lsd_pkg::IMSK_OFF, 32'h2);
    bus(1'b1, lsd_pkg::IST_OFF, 32'h3);
    sfault <= 8'h08;
    waitc(8);
    chk(48'(fline), 48'h0);
    chk(48'(irq), 48'h1);
    bus(1'b0, lsd_pkg::FLT_OFF, 32'h0);
    chk(48'(rd), 48'h08);
    sfault <= 8'h00;
    waitc(8);
    chk(48'(fline), 48'h0);
    bus(1'b0, lsd_pkg::FLT_OFF, 32'h0);
    waitc(2);
    chk(48'(fline), 48'h1);
    bus(1'b1, lsd_pkg::IST_OFF, 32'h2);
    waitc(2);
    chk(48'(irq), 48'h0);
    sfault <= 8'h01;
    waitc(8);
    chk(48'(fline), 48'h0);
    sfault <= 8'h00;
    en <= 1'b0;
    waitc(8);
    chk(48'(fline), 48'h1);
    chk(48'(gate), 48'h0);
    en <= 1'b1;
    $display("done fault");
  endtask
  // main sequence
  initial
  begin
    waitc(2);
    rst <= 1'b0;
    waitc(3);
    t_regs();
    t_pwm();
    t_dim();
    t_fault();
    stop_test();
  end
endmodule // lsd_core_tb_top
